// ===== ddm_ctl_model.sv
// Controller model for the DRAM link: makes CK, CKE, ODT and command pins.
// Assumes one bench process calls its tasks, one at a time.
`timescale 1ns/1ps
module ddm_ctl_model (
  output logic        o_ck,
  output logic        o_cke,
  output logic [3:0]  o_cmd,
  output logic [2:0]  o_ba,
  output logic [13:0] o_addr,
  output logic        o_odt
);
  localparam logic [3:0] CMD_DES = 4'hf;
  localparam int         T_SR    = 4;
  logic run;

  initial
  begin
    o_cke  = 1'b1;
    o_cmd  = CMD_DES;
    o_ba   = 3'h0;
    o_addr = 14'h0;
    o_odt  = 1'b0;
    run    = 1'b1;
    o_ck   = 1'b0;
    #1.3;
    forever
    begin
      #16;
      if (run || o_ck)
        o_ck = ~o_ck;
    end
  end

  // Deselect after each command; released lines show the inverse value
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
    @(posedge o_ck);
    o_cmd  <= c;
    o_ba   <= b;
    o_addr <= a;
    @(posedge o_ck);
    o_cmd  <= CMD_DES;
    o_ba   <= ~b;
    o_addr <= ~a;
  endtask : issue

  task automatic idle(input int n);
    repeat (n) @(posedge o_ck);
  endtask : idle

  task automatic set_odt(input logic v);
    @(posedge o_ck);
    o_odt <= v;
  endtask : set_odt

  // REFRESH with CKE falling enters self refresh, deselect enters power-down
  task automatic sr_enter(input logic [3:0] c);
    @(posedge o_ck);
    o_cmd <= c;
    o_cke <= 1'b0;
    @(posedge o_ck);
    o_cmd <= CMD_DES;
    idle(T_SR);
    run = 1'b0;
  endtask : sr_enter

  task automatic sr_exit();
    run = 1'b1;
    idle(T_SR);
    o_cke <= 1'b1;
    idle(T_SR);
  endtask : sr_exit
endmodule : ddm_ctl_model

// ===== ddm_dll_mode.sv
// DRAM-side DLL mode, self refresh and clock-change logic.
// Assumes commands are launched on the CK edge by the controller, which
// keeps its own ordering and timing duties; CK may stop in self refresh.
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
module ddm_dll_mode (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_ck,
  input  wire logic        i_cke,
  input  wire logic        i_cs_n,
  input  wire logic        i_ras_n,
  input  wire logic        i_cas_n,
  input  wire logic        i_we_n,
  input  wire logic [2:0]  i_ba,
  input  wire logic [13:0] i_addr,
  input  wire logic        i_odt,
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [31:0] o_reg_rdata,
  output logic             o_dll_off,
  output logic             o_dll_locked,
  output logic      [4:0]  o_cl_eff,
  output logic      [4:0]  o_cwl_eff,
  output logic             o_rd_launch,
  output logic             o_term_on,
  output logic             o_int_refresh
);

  ////////////////////////////////////////////////////////////////////////////
  // Latency helpers

  function automatic logic [4:0] ddm_cl(input logic [13:0] mr0,
                                        input logic [13:0] mr1);
    if (mr1[ddm_pkg::MR1_DLL_OFF_BIT])
      ddm_cl = ddm_pkg::DLL_OFF_CL;
    else
      ddm_cl = 5'(mr0[ddm_pkg::MR0_CL_LSB +: 3]) + ddm_pkg::CL_BASE;
  endfunction : ddm_cl

  function automatic logic [4:0] ddm_rd_lat(input logic [13:0] mr0,
                                            input logic [13:0] mr1);
    logic [4:0] cl;
    logic [4:0] al;
    cl = ddm_cl(mr0, mr1);
    unique case (mr1[ddm_pkg::MR1_AL_LSB +: 2])
      2'h1:    al = cl - 5'h01;
      2'h2:    al = cl - 5'h02;
      default: al = 5'h00;
    endcase
    // DLL off pulls the strobe window one cycle early
    ddm_rd_lat = al + cl - 5'(mr1[ddm_pkg::MR1_DLL_OFF_BIT]);
  endfunction : ddm_rd_lat

  ////////////////////////////////////////////////////////////////////////////
  // Link domain, clocked by CK

  typedef struct packed {
    ddm_pkg::ddm_link_st_type st;
    logic        cke_q;
    logic [13:0] mr0;
    logic [13:0] mr1;
    logic [13:0] mr2;
    logic [31:0] rd_pipe;
    logic [9:0]  dllk_cnt;
    logic        locked;
    logic [4:0]  cl_eff;
    logic [4:0]  cwl_eff;
    logic        term;
    logic        in_sr;
  } ddm_link_type;

  ddm_link_type l_r;
  ddm_link_type l_nxt;
  logic [3:0]   cmd;
  logic         cke_on;
  logic         rd_take;
  logic         mrs_take;

  assign cmd      = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
  assign cke_on   = i_cke && l_r.cke_q;
  assign rd_take  = (l_r.st == ddm_pkg::LS_IDLE) && cke_on && (cmd == ddm_pkg::CMD_READ);
  assign mrs_take = (l_r.st == ddm_pkg::LS_IDLE) && cke_on && (cmd == ddm_pkg::CMD_MRS);

  always_comb
  begin
    l_nxt         = l_r;
    l_nxt.cke_q   = i_cke;
    l_nxt.rd_pipe = l_r.rd_pipe >> 1;
    if (l_r.dllk_cnt != 10'h000)
      l_nxt.dllk_cnt = l_r.dllk_cnt - 10'h001;
    unique case (l_r.st)
      ddm_pkg::LS_IDLE:
      begin
        if (l_r.cke_q && !i_cke)
        begin
          // CKE falling with REFRESH enters self refresh, else power-down
          if (cmd == ddm_pkg::CMD_REF)
            l_nxt.st = ddm_pkg::LS_SR;
          else
            l_nxt.st = ddm_pkg::LS_PD;
        end
        else if (mrs_take)
        begin
          unique case (i_ba)
            ddm_pkg::MR0_SEL:
            begin
              l_nxt.mr0 = i_addr;
              if (i_addr[ddm_pkg::MR0_DLL_RST_BIT])
                l_nxt.dllk_cnt = ddm_pkg::T_DLLK_CK;
            end
            ddm_pkg::MR1_SEL: l_nxt.mr1 = i_addr;
            ddm_pkg::MR2_SEL: l_nxt.mr2 = i_addr;
            default:          l_nxt.mr2 = l_r.mr2;
          endcase
        end
        else if (rd_take)
          l_nxt.rd_pipe = l_nxt.rd_pipe
                          | (32'h1 << (ddm_rd_lat(l_r.mr0, l_r.mr1) - 5'h01));
      end
      // Held state keeps data; pins other than CKE are ignored
      ddm_pkg::LS_SR:
      begin
        if (i_cke)
          l_nxt.st = ddm_pkg::LS_IDLE;
      end
      ddm_pkg::LS_PD:
      begin
        if (i_cke)
          l_nxt.st = ddm_pkg::LS_IDLE;
      end
      default: l_nxt.st = ddm_pkg::LS_IDLE;
    endcase
    // A DLL reset must run its full count; turning the DLL off drops lock
    if (l_nxt.mr1[ddm_pkg::MR1_DLL_OFF_BIT])
      l_nxt.locked = 1'b0;
    // A fresh DLL reset outweighs a count that ends in the same cycle
    else if (l_nxt.dllk_cnt != 10'h000)
      l_nxt.locked = 1'b0;
    else if (l_r.dllk_cnt == 10'h001)
      l_nxt.locked = 1'b1;
    l_nxt.cl_eff = ddm_cl(l_nxt.mr0, l_nxt.mr1);
    if (l_nxt.mr1[ddm_pkg::MR1_DLL_OFF_BIT])
      l_nxt.cwl_eff = ddm_pkg::DLL_OFF_CWL;
    else
      l_nxt.cwl_eff = 5'(l_nxt.mr2[ddm_pkg::MR2_CWL_LSB +: 3]) + ddm_pkg::CWL_BASE;
    // No termination with the DLL off, in self refresh or in power-down
    l_nxt.term = i_odt && !l_nxt.mr1[ddm_pkg::MR1_DLL_OFF_BIT]
                 && (l_nxt.st == ddm_pkg::LS_IDLE)
                 && (l_nxt.mr1[ddm_pkg::MR1_RTT_B0] || l_nxt.mr1[ddm_pkg::MR1_RTT_B1]
                     || l_nxt.mr1[ddm_pkg::MR1_RTT_B2]);
    // Registered so that only a flop output crosses to the core clock
    l_nxt.in_sr = (l_nxt.st == ddm_pkg::LS_SR);
  end

  always_ff @(posedge i_ck or posedge i_reset)
  begin
    if (i_reset)
    begin
      l_r          <= '0;
      l_r.st       <= ddm_pkg::LS_IDLE;
      l_r.cl_eff   <= ddm_pkg::CL_BASE;
      l_r.cwl_eff  <= ddm_pkg::CWL_BASE;
    end
    else
      l_r <= l_nxt;
  end

  assign o_dll_off    = l_r.mr1[ddm_pkg::MR1_DLL_OFF_BIT];
  assign o_dll_locked = l_r.locked;
  assign o_cl_eff     = l_r.cl_eff;
  assign o_cwl_eff    = l_r.cwl_eff;
  // Launch marks the CK edge where the DQS access window opens; with the DLL
  // off the strobe then trails by 1 to 10 ns, possibly past one CK period
  assign o_rd_launch  = l_r.rd_pipe[0];
  assign o_term_on    = l_r.term;

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: crossing, internal refresh, register port

  logic [2:0] lvl_q;
  logic       sr_q;
  logic       dll_off_q;
  logic       locked_q;

  ddm_sync #(
    .W (3)
  ) u_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_d     ({l_r.locked, l_r.in_sr, l_r.mr1[ddm_pkg::MR1_DLL_OFF_BIT]}),
    .o_q     (lvl_q)
  );

  assign dll_off_q = lvl_q[0];
  assign sr_q      = lvl_q[1];
  assign locked_q  = lvl_q[2];

  typedef struct packed {
    logic [7:0]  sre_cnt;
    logic        ck_ign;
    logic [15:0] refi;
    logic [15:0] tmr;
    logic [15:0] ref_cnt;
    logic        int_ref;
    logic [31:0] rdata;
  } ddm_core_type;

  ddm_core_type c_r;
  ddm_core_type c_nxt;

  always_comb
  begin
    c_nxt         = c_r;
    c_nxt.int_ref = 1'b0;
    c_nxt.rdata   = 32'h0000_0000;
    if (!sr_q)
    begin
      c_nxt.sre_cnt = ddm_pkg::CKSRE_CYC;
      c_nxt.ck_ign  = 1'b0;
      c_nxt.tmr     = c_r.refi;
    end
    else
    begin
      if (c_r.sre_cnt > 8'h01)
        c_nxt.sre_cnt = c_r.sre_cnt - 8'h01;
      else
        c_nxt.ck_ign = 1'b1;
      // Refresh timer runs on the core clock, so CK may stop entirely
      if (c_r.tmr <= 16'h0001)
      begin
        c_nxt.int_ref = 1'b1;
        c_nxt.tmr     = c_r.refi;
        c_nxt.ref_cnt = c_r.ref_cnt + 16'h0001;
      end
      else
        c_nxt.tmr = c_r.tmr - 16'h0001;
    end
    if (i_reg_wr && (i_reg_addr == ddm_pkg::REG_CTRL))
      c_nxt.refi = i_reg_wdata[15:0];
    if (i_reg_rd)
    begin
      unique case (i_reg_addr)
        ddm_pkg::REG_CTRL:
          c_nxt.rdata = {16'h0000, c_r.refi};
        ddm_pkg::REG_STATUS:
        begin
          c_nxt.rdata[ddm_pkg::ST_DLL_OFF]           = dll_off_q;
          c_nxt.rdata[ddm_pkg::ST_IN_SR]             = sr_q;
          c_nxt.rdata[ddm_pkg::ST_CK_IGN]            = c_r.ck_ign;
          c_nxt.rdata[ddm_pkg::ST_LOCKED]            = locked_q;
          c_nxt.rdata[ddm_pkg::ST_REF_LSB +: 16]     = c_r.ref_cnt;
        end
        default:
          c_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      c_r         <= '0;
      c_r.sre_cnt <= ddm_pkg::CKSRE_CYC;
      c_r.refi    <= ddm_pkg::REFI_CYC;
      c_r.tmr     <= ddm_pkg::REFI_CYC;
    end
    else
      c_r <= c_nxt;
  end

  assign o_reg_rdata   = c_r.rdata;
  assign o_int_refresh = c_r.int_ref;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  dll_bit_a: assert property (@(posedge i_ck) disable iff (i_reset)
    (mrs_take && i_ba == ddm_pkg::MR1_SEL) |=> (o_dll_off == $past(i_addr[0])))
    else $error("DLL mode does not follow MR1 bit 0");

  fixed_lat_a: assert property (@(posedge i_ck) disable iff (i_reset)
    o_dll_off |-> (o_cl_eff == 5'h06 && o_cwl_eff == 5'h06))
    else $error("DLL off but latencies are not 6");

  rd_window_a: assert property (@(posedge i_ck) disable iff (i_reset)
    (rd_take && o_dll_off && l_r.mr1[4:3] == 2'h0) |-> ##5 o_rd_launch)
    else $error("DLL off read window not at AL+CL-1");

  rd_early_a: assert property (@(posedge i_ck) disable iff (i_reset)
    (rd_take && o_dll_off && l_r.mr1[4:3] == 2'h0 && l_r.rd_pipe == 32'h0)
    |-> !o_rd_launch [*5])
    else $error("DLL off read window opened early");

  sr_hold_a: assert property (@(posedge i_ck) disable iff (i_reset)
    (l_r.st == ddm_pkg::LS_SR && !i_cke) |=> ($stable(l_r.mr1) && $stable(l_r.mr0)))
    else $error("Mode changed while in self refresh");

  ck_ign_a: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(sr_q) |-> !c_r.ck_ign ##3 c_r.ck_ign)
    else $error("Clock ignore not set after tCKSRE");

  retain_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (sr_q && c_r.tmr == 16'h0002 && $stable(sr_q)) |=> ##1 (o_int_refresh || !sr_q))
    else $error("Internal refresh missed in self refresh");

  no_term_a: assert property (@(posedge i_ck) disable iff (i_reset)
    o_dll_off |-> !o_term_on)
    else $error("Termination on with DLL off");

  rd_on_a: assert property (@(posedge i_ck) disable iff (i_reset)
    (rd_take && !o_dll_off && l_r.mr1[4:3] == 2'h0 && l_r.mr0[6:4] == 3'h2)
    |-> ##6 o_rd_launch)
    else $error("DLL on read window not at AL+CL");

  dll_rst_a: assert property (@(posedge i_ck) disable iff (i_reset)
    (mrs_take && i_ba == ddm_pkg::MR0_SEL && i_addr[ddm_pkg::MR0_DLL_RST_BIT])
    |=> !o_dll_locked)
    else $error("Lock kept across a DLL reset");

  pd_hold_a: assert property (@(posedge i_ck) disable iff (i_reset)
    (l_r.st == ddm_pkg::LS_PD && !i_cke)
    |=> ($stable(l_r.mr0) && $stable(l_r.mr1) && $stable(l_r.mr2)))
    else $error("Mode changed while in power-down");

  term_idle_a: assert property (@(posedge i_ck) disable iff (i_reset)
    (l_r.st != ddm_pkg::LS_IDLE) |-> !o_term_on)
    else $error("Termination on outside idle");

  cke_exit_a: assert property (@(posedge i_ck) disable iff (i_reset)
    (l_r.st != ddm_pkg::LS_IDLE && i_cke) |=> (l_r.st == ddm_pkg::LS_IDLE))
    else $error("CKE high did not return to idle");

  sr_enter_c: cover property (@(posedge i_ck) disable iff (i_reset)
    l_r.st == ddm_pkg::LS_IDLE ##1 l_r.st == ddm_pkg::LS_SR);
  off_read_c: cover property (@(posedge i_ck) disable iff (i_reset)
    o_dll_off && o_rd_launch);
  lock_c: cover property (@(posedge i_ck) disable iff (i_reset)
    $rose(o_dll_locked));
  int_ref_c: cover property (@(posedge i_clk) disable iff (i_reset)
    o_int_refresh);
  pd_enter_c: cover property (@(posedge i_ck) disable iff (i_reset)
    l_r.st == ddm_pkg::LS_PD);
endmodule : ddm_dll_mode

// ===== ddm_pkg.sv
// Constants, encodings and types for the DRAM DLL-mode and clock-change block.
// Assumes a 250 MHz core clock and a DDR3-style command bus sampled on CK.
package ddm_pkg;
  // Command pins {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS  = 4'h0;
  localparam logic [3:0] CMD_REF  = 4'h1;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [2:0] MR0_SEL  = 3'h0;
  localparam logic [2:0] MR1_SEL  = 3'h1;
  localparam logic [2:0] MR2_SEL  = 3'h2;
  localparam int MR1_DLL_OFF_BIT  = 0;
  localparam int MR0_DLL_RST_BIT  = 8;
  localparam int MR0_CL_LSB       = 4;
  localparam int MR1_AL_LSB       = 3;
  localparam int MR2_CWL_LSB      = 3;
  localparam int MR1_RTT_B0       = 2;
  localparam int MR1_RTT_B1       = 6;
  localparam int MR1_RTT_B2       = 9;
  localparam logic [4:0] CL_BASE      = 5'h04;
  localparam logic [4:0] CWL_BASE     = 5'h05;
  localparam logic [4:0] DLL_OFF_CL   = 5'h06;
  localparam logic [4:0] DLL_OFF_CWL  = 5'h06;
  localparam logic [9:0] T_DLLK_CK    = 10'h200;
  localparam int DQSCK_OFF_MIN_NS = 1;
  localparam int DQSCK_OFF_MAX_NS = 10;
  localparam int CLK_NS           = 4;
  localparam int T_CKSRE_NS       = 10;
  localparam logic [7:0] CKSRE_CYC = 8'((T_CKSRE_NS + CLK_NS - 1) / CLK_NS);
  localparam int T_REFI_NS        = 7800;
  localparam logic [15:0] REFI_CYC = 16'(T_REFI_NS / CLK_NS);
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int ST_DLL_OFF  = 0;
  localparam int ST_IN_SR    = 1;
  localparam int ST_CK_IGN   = 2;
  localparam int ST_LOCKED   = 3;
  localparam int ST_REF_LSB  = 16;

  typedef enum logic [1:0] {LS_IDLE, LS_SR, LS_PD} ddm_link_st_type;
endpackage : ddm_pkg

// ===== ddm_sync.sv
// Two-flop level synchroniser, one flop pair per bit.
// Assumes each bit is an independent slow level.
`timescale 1ns/1ps
module ddm_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ddm_sync_st_type;

  ddm_sync_st_type s_r;
  ddm_sync_st_type s_nxt;

  always_comb
  begin
    s_nxt    = s_r;
    s_nxt.s1 = i_d;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign o_q = s_r.s2;
endmodule : ddm_sync

// ===== dram_dll_mode_and_clock_change_bench.sv
// Self-checking bench for the DLL-mode block, with the controller model.
// Assumes the register map and latencies of the design hand-over.
`timescale 1ns/1ps
module dram_dll_mode_and_clock_change_bench;
  typedef struct {logic [13:0] mr0; logic [13:0] mr1; logic [4:0] cl;
                  logic [4:0] cwl; logic off; int lat;} ddm_row_type;
  ddm_row_type rows [4] = '{'{14'h0020, 14'h0000, 5'h06, 5'h05, 1'b0, 6},
                            '{14'h0030, 14'h0008, 5'h07, 5'h05, 1'b0, 13},
                            '{14'h0020, 14'h0001, 5'h06, 5'h06, 1'b1, 5},
                            '{14'h0010, 14'h0011, 5'h06, 5'h06, 1'b1, 9}};
  logic        i_clk, i_reset, ck, cke, odt, reg_wr, reg_rd;
  logic        dll_off, dll_locked, rd_launch, term_on, int_refresh;
  logic [3:0]  cmd, reg_addr;
  logic [2:0]  ba;
  logic [13:0] addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [4:0]  cl_eff, cwl_eff;
  int          bad_count, n_compared, n;

  ddm_ctl_model u_ctl (.o_ck(ck), .o_cke(cke), .o_cmd(cmd), .o_ba(ba), .o_addr(addr),
                       .o_odt(odt));
  ddm_dll_mode u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_ck(ck), .i_cke(cke),
    .i_cs_n(cmd[3]), .i_ras_n(cmd[2]), .i_cas_n(cmd[1]), .i_we_n(cmd[0]), .i_ba(ba),
    .i_addr(addr), .i_odt(odt), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .o_dll_off(dll_off),
    .o_dll_locked(dll_locked), .o_cl_eff(cl_eff), .o_cwl_eff(cwl_eff),
    .o_rd_launch(rd_launch), .o_term_on(term_on), .o_int_refresh(int_refresh));

  always #2 i_clk = ~i_clk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge i_clk);
    reg_wr    <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
    @(posedge i_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge i_clk);
    reg_rd   <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : reg_read

  // Counts CK edges from the READ edge to the edge that samples the launch
  task automatic read_lat(output int k);
    u_ctl.issue(ddm_pkg::CMD_READ, 3'h0, 14'h0);
    k = 0;
    while (rd_launch !== 1'b1 && k < 20)
    begin
      @(posedge ck);
      k++;
    end
  endtask : read_lat

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  initial
  begin
    #200000;
    bad_count++;
    conclude();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_clk = 1'b0;
    i_reset = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    bad_count = 0;
    n_compared = 0;
    repeat (16) @(posedge i_clk);
    i_reset <= 1'b0;
    #1;
    chk("reset_cl", 32'h4, 32'(cl_eff));
    chk("reset_cwl", 32'h5, 32'(cwl_eff));
    chk("reset_off", 32'h0, 32'(dll_off));
    reg_read(4'h0, d);
    chk("ctrl_reset", 32'h0000079e, d);
    reg_write(4'h0, 32'h00000004);
    reg_write(4'h8, 32'h0000ffff);
    reg_read(4'h8, d);
    chk("unmapped", 32'h0, d);
    reg_read(4'h0, d);
    chk("ctrl", 32'h00000004, d);
    u_ctl.idle(4);
    u_ctl.issue(4'h0, 3'h2, 14'h0000);
    u_ctl.idle(4);
    for (int r = 0; r < 4; r++)
    begin
      u_ctl.issue(4'h0, 3'h0, rows[r].mr0);
      u_ctl.idle(4);
      u_ctl.issue(4'h0, 3'h1, rows[r].mr1);
      u_ctl.idle(4);
      chk("dll_off", 32'(rows[r].off), 32'(dll_off));
      chk("cl_eff", 32'(rows[r].cl), 32'(cl_eff));
      chk("cwl_eff", 32'(rows[r].cwl), 32'(cwl_eff));
      read_lat(n);
      chk("rd_lat", 32'(rows[r].lat), 32'(n));
      u_ctl.idle(4);
    end
    reg_read(4'h4, d);
    chk("status_off", 32'h1, 32'(d[0]));
    u_ctl.set_odt(1'b1);
    u_ctl.idle(2);
    chk("term_off", 32'h0, 32'(term_on));
    u_ctl.issue(4'h0, 3'h1, 14'h0004);
    u_ctl.idle(2);
    chk("term_on", 32'h1, 32'(term_on));
    u_ctl.set_odt(1'b0);
    u_ctl.idle(4);
    u_ctl.sr_enter(ddm_pkg::CMD_REF);
    repeat (10) @(posedge i_clk);
    reg_read(4'h4, d);
    chk("sr_ign", 32'h3, 32'(d[2:1]));
    n = 0;
    while (int_refresh !== 1'b1 && n < 20)
    begin
      @(posedge i_clk);
      n++;
    end
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (int_refresh !== 1'b1 && n < 20);
    chk("refresh_gap", 32'd4, 32'(n));
    // Sixteen core cycles between the two status samples hold four pulses
    reg_read(4'h4, d);
    n = int'(d[31:16]);
    repeat (14) @(posedge i_clk);
    reg_read(4'h4, d);
    chk("ref_count", 32'd4, 32'(d[31:16]) - 32'(n));
    u_ctl.sr_exit();
    reg_read(4'h4, d);
    chk("sr_left", 32'h0, 32'(d[1]));
    u_ctl.issue(4'h0, 3'h1, 14'h0000);
    u_ctl.idle(4);
    u_ctl.issue(4'h0, 3'h0, 14'h0120);
    n = 0;
    while (dll_locked !== 1'b1 && n < 600)
    begin
      @(posedge ck);
      n++;
    end
    chk("lock_ck", 32'(ddm_pkg::T_DLLK_CK) + 32'd1, 32'(n));
    reg_read(4'h4, d);
    chk("status_lock", 32'h1, 32'(d[3]));
    // Clock stop and restart in precharge power-down, then a fresh DLL reset
    u_ctl.sr_enter(4'hf);
    repeat (10) @(posedge i_clk);
    reg_read(4'h4, d);
    chk("pd_not_sr", 32'h0, 32'(d[2:1]));
    u_ctl.sr_exit();
    u_ctl.issue(4'h0, 3'h0, 14'h0120);
    u_ctl.idle(1);
    chk("relock_start", 32'h0, 32'(dll_locked));
    u_ctl.issue(4'h0, 3'h1, 14'h0001);
    u_ctl.idle(2);
    chk("lock_clear", 32'h0, 32'(dll_locked));
    // Second reset in mid-run, from DLL off with a changed interval
    @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (16) @(posedge i_clk);
    i_reset <= 1'b0;
    #1;
    chk("rst2_cl", 32'(ddm_pkg::CL_BASE), 32'(cl_eff));
    chk("rst2_off", 32'h0, 32'(dll_off));
    reg_read(4'h0, d);
    chk("rst2_ctrl", 32'(ddm_pkg::REFI_CYC), d);
    u_ctl.idle(2);
    u_ctl.issue(4'h0, 3'h1, 14'h0001);
    u_ctl.idle(2);
    chk("rst2_link", 32'h1, 32'(dll_off));
    conclude();
  end
endmodule : dram_dll_mode_and_clock_change_bench
